// ### rtl/wg_steer_pkg.sv
// Constants and carriers for the waveform generator input and steering block.
// Assumes one 50 MHz clock and a plain strobe register port.
package wg_steer_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [3:0] ADDR_CLK_SRC = 4'h0; // gen_clock_source_select
   localparam logic [3:0] ADDR_DAT_SEL = 4'h1; // gen_data_input_select
   localparam logic [3:0] ADDR_STEER = 4'h2; // output_steering_control
   localparam logic [3:0] ADDR_POLARITY = 4'h3; // polarity bits, own register
   localparam logic [3:0] ADDR_STATUS = 4'h4; // live data input level, read only

   // ----------------------------------------------------------------
   // Reset values and field positions
   // ----------------------------------------------------------------
   localparam logic [7:0] RST_CLK_SRC = 8'h00;
   localparam logic [7:0] RST_DAT_SEL = 8'h00;
   localparam logic [7:0] RST_STEER = 8'h00;
   localparam logic [7:0] RST_POLARITY = 8'h00;
   localparam int CLK_SRC_BIT = 0;
   localparam int DAT_SEL_LSB = 0;
   localparam int STEER_EN_LSB = 0;
   localparam int STEER_DATA_LSB = 4;
   localparam int NUM_CHAN = 4;

   // ----------------------------------------------------------------
   // Data input select codes
   // ----------------------------------------------------------------
   localparam logic [3:0] SEL_PIN = 4'h0;
   localparam logic [3:0] SEL_LAST_VALID = 4'hd;
   localparam logic [3:0] SEL_RESERVED_LO = 4'he;

   // Register bus request
   typedef struct packed {
      logic [3:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } reg_req_s;

endpackage

// ### rtl/data_input_mux.sv
// Data input source selector for the waveform generator.
// Assumes all sources are synchronous levels in the clk domain.
`timescale 1ns/1ps
module data_input_mux #(
   parameter int NUM_SRC = 14
) (
   // Selection
   input wire logic [3:0] sel,
   // Sources, index 0 is the remappable pin
   input wire logic [NUM_SRC-1:0] src,
   // Selected level
   output logic data_in
);

   // The code table is fixed at fourteen sources, so refuse any other count
   if (NUM_SRC != 14) begin : g_num_src_check
      $error("data_input_mux serves exactly 14 sources");
   end

   // ----------------------------------------------------------------
   // Selection
   // ----------------------------------------------------------------
   // Reserved codes give a quiet low level, never a live source
   always_comb begin
      if (sel > wg_steer_pkg::SEL_LAST_VALID) begin
         data_in = 1'b0;
      end else begin
         data_in = src[sel];
      end
   end

endmodule

// ### rtl/wg_input_steer.sv
// Waveform generator clock select, data input select and output steering.
// Assumes synchronous source levels and a strobe register port on clk.
`timescale 1ns/1ps

module wg_input_steer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Sleep indication from the power controller
   input wire logic sleep,
   // Data sources
   input wire logic remappable_pin_input,
   input wire logic comparator_one_output,
   input wire logic comparator_two_output,
   input wire logic [3:0] capture_compare_units,
   input wire logic pulse_width_unit_five,
   input wire logic pulse_width_unit_six,
   input wire logic numeric_oscillator_one,
   input wire logic [3:0] logic_cells,
   // Generator clock control
   output logic gen_clk_internal_sel,
   output logic internal_osc_request,
   // Steered channel outputs a to d
   output logic [3:0] chan_out
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic clk_src;
      logic [3:0] dat_sel;
      logic [7:0] steer;
      logic [3:0] polarity;
      logic [7:0] rdata;
      logic clk_sel;
      logic osc_req;
      logic [3:0] chan;
   } state_s;

   state_s state_r;
   state_s state_nxt;
   wg_steer_pkg::reg_req_s req;
   logic [13:0] sources;
   logic data_in;

   // Gather the bus and the sources
   assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
   assign sources = {logic_cells, numeric_oscillator_one, pulse_width_unit_six,
                     pulse_width_unit_five, capture_compare_units,
                     comparator_two_output, comparator_one_output,
                     remappable_pin_input};

   // ----------------------------------------------------------------
   // Source selector
   // ----------------------------------------------------------------
   data_input_mux #(
      .NUM_SRC(14)
   ) u_mux (
      .sel(state_r.dat_sel),
      .src(sources),
      .data_in(data_in)
   );

   // Steered value of one channel
   function automatic logic steer_chan(input logic en, input logic ovr,
                                       input logic pol, input logic din);
      steer_chan = en ? (din ^ pol) : ovr;
   endfunction

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      state_nxt = state_r;
      // Register writes
      if (req.wr) begin
         unique case (req.addr)
            wg_steer_pkg::ADDR_CLK_SRC: begin
               state_nxt.clk_src = req.wdata[wg_steer_pkg::CLK_SRC_BIT];
            end
            wg_steer_pkg::ADDR_DAT_SEL: begin
               state_nxt.dat_sel = req.wdata[wg_steer_pkg::DAT_SEL_LSB +: 4];
            end
            wg_steer_pkg::ADDR_STEER: begin
               state_nxt.steer = req.wdata;
            end
            wg_steer_pkg::ADDR_POLARITY: begin
               state_nxt.polarity = req.wdata[3:0];
            end
            default: begin
            end
         endcase
      end
      // Read data stand only in the cycle after the strobe
      state_nxt.rdata = 8'h00;
      if (req.rd) begin
         unique case (req.addr)
            wg_steer_pkg::ADDR_CLK_SRC: begin
               state_nxt.rdata = {7'h00, state_r.clk_src};
            end
            wg_steer_pkg::ADDR_DAT_SEL: begin
               state_nxt.rdata = {4'h0, state_r.dat_sel};
            end
            wg_steer_pkg::ADDR_STEER: begin
               state_nxt.rdata = state_r.steer;
            end
            wg_steer_pkg::ADDR_POLARITY: begin
               state_nxt.rdata = {4'h0, state_r.polarity};
            end
            wg_steer_pkg::ADDR_STATUS: begin
               state_nxt.rdata = {7'h00, data_in};
            end
            default: begin
               state_nxt.rdata = 8'h00;
            end
         endcase
      end
      // Clock choice; the request holds the oscillator up through sleep
      state_nxt.clk_sel = state_r.clk_src;
      state_nxt.osc_req = state_r.clk_src;
      // Channels, registered so outputs never glitch on a select change
      for (int i = 0; i < wg_steer_pkg::NUM_CHAN; i++) begin
         state_nxt.chan[i] = steer_chan(state_r.steer[wg_steer_pkg::STEER_EN_LSB + i],
                                        state_r.steer[wg_steer_pkg::STEER_DATA_LSB + i],
                                        state_r.polarity[i], data_in);
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state_r.clk_src <= wg_steer_pkg::RST_CLK_SRC[0];
         state_r.dat_sel <= wg_steer_pkg::RST_DAT_SEL[3:0];
         state_r.steer <= wg_steer_pkg::RST_STEER;
         state_r.polarity <= wg_steer_pkg::RST_POLARITY[3:0];
         state_r.rdata <= 8'h00;
         state_r.clk_sel <= 1'b0;
         state_r.osc_req <= 1'b0;
         state_r.chan <= 4'h0;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Outputs straight from flip-flops
   assign reg_rdata = state_r.rdata;
   assign gen_clk_internal_sel = state_r.clk_sel;
   assign internal_osc_request = state_r.osc_req;
   assign chan_out = state_r.chan;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   chk_clk_select: assert property (@(posedge clk) disable iff (!rst_n)
      $past(reg_wr) && $past(reg_addr) == wg_steer_pkg::ADDR_CLK_SRC
      |=> gen_clk_internal_sel == $past(reg_wdata[0], 2))
      else $error("clock select does not follow register");

   chk_osc_sleep: assert property (@(posedge clk) disable iff (!rst_n)
      sleep && state_r.clk_src |=> internal_osc_request)
      else $error("internal oscillator dropped in sleep");

   chk_clk_rdata: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == wg_steer_pkg::ADDR_CLK_SRC |=> reg_rdata[7:1] == 7'h00)
      else $error("clock register upper bits not zero");

   chk_dat_rdata: assert property (@(posedge clk) disable iff (!rst_n)
      reg_rd && reg_addr == wg_steer_pkg::ADDR_DAT_SEL
      |=> reg_rdata == {4'h0, $past(state_r.dat_sel)})
      else $error("data select readback wrong");

   chk_dat_write: assert property (@(posedge clk) disable iff (!rst_n)
      reg_wr && reg_addr == wg_steer_pkg::ADDR_DAT_SEL
      |=> state_r.dat_sel == $past(reg_wdata[3:0]))
      else $error("data select not stored");

   chk_route_pin: assert property (@(posedge clk) disable iff (!rst_n)
      state_r.dat_sel == wg_steer_pkg::SEL_PIN |-> data_in == remappable_pin_input)
      else $error("pin code does not route the pin");

   chk_route_last: assert property (@(posedge clk) disable iff (!rst_n)
      state_r.dat_sel == wg_steer_pkg::SEL_LAST_VALID |-> data_in == logic_cells[3])
      else $error("last code does not route logic cell four");

   // Read data must fall back to zero when no read was taken
   chk_rdata_idle: assert property (@(posedge clk) disable iff (!rst_n)
      !reg_rd |=> reg_rdata == 8'h00)
      else $error("read data stands without a read");

   chk_reserved_low: assert property (@(posedge clk) disable iff (!rst_n)
      state_r.dat_sel >= wg_steer_pkg::SEL_RESERVED_LO |-> !data_in)
      else $error("reserved code passes a source");

   chk_steer_wave: assert property (@(posedge clk) disable iff (!rst_n)
      state_r.steer[0] && $stable(state_r.steer)
      |=> chan_out[0] == ($past(data_in) ^ $past(state_r.polarity[0])))
      else $error("channel a not carrying waveform");

   chk_steer_data_b: assert property (@(posedge clk) disable iff (!rst_n)
      !state_r.steer[1] |=> chan_out[1] == $past(state_r.steer[5]))
      else $error("channel b not holding steering data");

   chk_steer_data: assert property (@(posedge clk) disable iff (!rst_n)
      !state_r.steer[3] |=> chan_out[3] == $past(state_r.steer[7]))
      else $error("channel d not holding steering data");

endmodule

// ### tb/src_model.sv
// On-chip source levels that feed the data input selector.
// Assumes the bench sets a pattern; levels change one clk after it.
`timescale 1ns/1ps
module src_model (
   // Clock
   input wire logic clk,
   // Pattern, bit 0 the pin, bit 13 logic cell four
   input wire logic [13:0] pat,
   // Source levels
   output logic [13:0] lvl
);
   // Registered like real peripheral outputs, never combinational
   always_ff @(posedge clk) begin
      lvl <= pat;
   end
endmodule

// ### tb/wg_input_steer_tb.sv
// Self-checking bench for the generator input select and steering.
// Assumes src_model drives all fourteen source levels.
`timescale 1ns/1ps
module wg_input_steer_tb;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic slp = 1'b0;
   logic [13:0] pat = 14'h0000;
   logic [13:0] lvl;
   logic [7:0] rdata;
   logic osel;
   logic oreq;
   logic [3:0] chan;
   int miscompares = 0;
   int comparisons = 0;

   // ----------------------------------------------------------------
   // Clock, partner and design
   // ----------------------------------------------------------------
   always #10 clk = ~clk;
   src_model model_u (.clk(clk), .pat(pat), .lvl(lvl));
   wg_input_steer dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(addr), .reg_wdata(wdata),
      .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .sleep(slp),
      .remappable_pin_input(lvl[0]), .comparator_one_output(lvl[1]),
      .comparator_two_output(lvl[2]), .capture_compare_units(lvl[6:3]),
      .pulse_width_unit_five(lvl[7]), .pulse_width_unit_six(lvl[8]),
      .numeric_oscillator_one(lvl[9]), .logic_cells(lvl[13:10]),
      .gen_clk_internal_sel(osel), .internal_osc_request(oreq), .chan_out(chan));

   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd_check(input logic [3:0] a, input logic [7:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      check("reg", exp, rdata);
   endtask
   // Covers write-to-output and source-to-output paths
   task automatic settle();
      repeat (3) @(posedge clk);
      #1;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic t_reset();
      for (int i = 0; i < 4; i++) begin
         rd_check(i[3:0], 8'h00);
      end
      check("chan", 8'h00, {4'h0, chan});
      check("osel", 8'h00, {7'h0, osel});
   endtask
   // Sleep held high: internal oscillator must stay requested
   task automatic t_clock();
      @(posedge clk);
      slp <= 1'b1;
      wr_reg(4'h0, 8'hff);
      settle();
      check("osel", 8'h01, {7'h0, osel});
      check("oreq", 8'h01, {7'h0, oreq});
      rd_check(4'h0, 8'h01);
      wr_reg(4'h0, 8'h00);
      slp <= 1'b0;
      settle();
      check("osel", 8'h00, {7'h0, osel});
      check("oreq", 8'h00, {7'h0, oreq});
   endtask
   // Each valid code with one source high, then all but that one; reserved codes with all sources high
   task automatic t_select();
      logic [13:0] one;
      wr_reg(4'h3, 8'h00);
      wr_reg(4'h2, 8'h0f);
      for (int c = 0; c < 16; c++) begin
         one = (c < 14) ? (14'h0001 << c) : 14'h3fff;
         wr_reg(4'h1, {4'hf, c[3:0]});
         pat <= one;
         settle();
         check("chan", (c < 14) ? 8'h0f : 8'h00, {4'h0, chan});
         rd_check(4'h1, {4'h0, c[3:0]});
         pat <= (c < 14) ? ~one : 14'h3fff;
         settle();
         check("chan", 8'h00, {4'h0, chan});
      end
   endtask
   // Mixed enables, steering data and polarity per channel
   task automatic t_steer();
      wr_reg(4'h1, 8'h00);
      wr_reg(4'h3, 8'h03);
      wr_reg(4'h2, 8'ha5);
      pat <= 14'h0001;
      settle();
      check("chan", 8'h0e, {4'h0, chan});
      rd_check(4'h4, 8'h01);
      pat <= 14'h0000;
      settle();
      check("chan", 8'h0b, {4'h0, chan});
      rd_check(4'h4, 8'h00);
      rd_check(4'h2, 8'ha5);
      rd_check(4'h9, 8'h00);
   endtask

   // ----------------------------------------------------------------
   // Sequence, watchdog and verdict
   // ----------------------------------------------------------------
   task automatic summarize();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      t_reset();
      t_clock();
      t_select();
      t_steer();
      summarize();
   end
   // Whole run needs well under a thousand cycles
   initial begin
      repeat (5000) @(posedge clk);
      miscompares++;
      summarize();
   end
endmodule
